// file: hw/isc_pkg.sv
/*
 * constants, state codes and field layout of the i2c data/command port
 * and standard-speed scl timing block.
 * assumes: imported by isc_top and the testbench; no timing figures in ns.
 */
package isc_pkg;
// Function
// - data field low byte: byte to send on write, last received on read
// - reading data field returns the byte received on the bus
// - each data/command write becomes a transmit queue entry with direction bit (code: a write while tx_queue_full is set is dropped)
// - master: direction 0 writes on the bus, 1 reads from the bus
// - slave: direction bit chooses only in slave transmit; ignored in slave receive
// - slave transmit: entry with direction 0 sends its data byte
// - read command while general-call enable set raises transmit abort (code: in master mode only)
// - read command after read-request flag raises transmit abort
// - entry with stop bit set ends the transfer with a stop
// - scl high count for standard speed is a 14-bit field
// - scl low count for standard speed is a 14-bit field
// - count registers take writes only while global enable is 0
// - high count written below 6 stores 6
// - low count written below 8 stores 8
// - reset values: high count 0x190, low count 0x1d6
// - general-call enable 1 allows general call, 0 blocks it (code: no general-call handling; the bit only aborts master read commands)

   // ===================================================================
   // register map
   localparam int ISC_AW = 8;
   localparam logic [ISC_AW-1:0] ISC_DATA_OFS = 8'h10;
   localparam logic [ISC_AW-1:0] ISC_HI_OFS = 8'h14;
   localparam logic [ISC_AW-1:0] ISC_LO_OFS = 8'h18;
   localparam int ISC_DW = 32;

   // ===================================================================
   // fields
   localparam int ISC_CNT_W = 14;
   localparam int ISC_ENT_W = 10;
   localparam int ISC_CMD_BIT = 8;
   localparam int ISC_STOP_BIT = 9;
   localparam logic [ISC_CNT_W-1:0] ISC_HI_RST = 14'h0190;
   localparam logic [ISC_CNT_W-1:0] ISC_LO_RST = 14'h01d6;
   localparam logic [ISC_CNT_W-1:0] ISC_HI_MIN = 14'h0006;
   localparam logic [ISC_CNT_W-1:0] ISC_LO_MIN = 14'h0008;
   localparam logic [3:0] ISC_LAST_BIT = 4'h8;

   // ===================================================================
   // link engine states
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_START = 6'h02,
      ST_BIT = 6'h04,
      ST_STOP = 6'h08,
      ST_WAIT = 6'h10,
      ST_STX = 6'h20
   } isc_state_t;
endpackage: isc_pkg

// file: hw/isc_sync.sv
/*
 * two-flop synchroniser for a bundle of independent levels.
 * assumes: each bit changes alone; words cross elsewhere by handshake.
 */
`timescale 1ns/1ps
module isc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   if (W < 1) begin : g_bad
      $error("isc_sync: width must be at least 1");
   end

   // first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule: isc_sync

// file: hw/isc_tmr.sv
/*
 * down counter for one scl phase; done is high for one cycle.
 * assumes: load pulses while idle; val at least 2.
 */
`timescale 1ns/1ps
module isc_tmr #(
   parameter int W = 14
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic load,
   input wire logic [W-1:0] val,
   output logic done
);
   logic [W-1:0] cnt_reg;

   if (W < 4) begin : g_bad
      $error("isc_tmr: width too small for minimum counts");
   end

   // loads val-1 so that load register plus count spans val cycles
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_reg <= '0;
      end else if (load) begin
         cnt_reg <= val - W'(1);
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - W'(1);
      end
   end

   assign done = (cnt_reg == W'(1));
endmodule: isc_tmr

// file: hw/isc_top.sv
/*
 * data/command port, standard-speed scl counts and a byte engine
 * on the link clock driving open-drain scl/sda.
 * assumes: register port on sys_clk; link_clk free running with its
 * own synchronous reset; address bytes are sent as data entries.
 */
`timescale 1ns/1ps
module isc_top (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [isc_pkg::ISC_AW-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [isc_pkg::ISC_DW-1:0] reg_wdata,
   output logic [isc_pkg::ISC_DW-1:0] reg_rdata,
   input wire logic global_enable,
   input wire logic master_mode,
   input wire logic slave_tx_mode,
   input wire logic general_call_enable,
   input wire logic read_request_flag,
   output logic tx_abort,
   output logic tx_queue_full,
   output logic rx_full,
   input wire logic link_clk,
   input wire logic link_rstn,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   import isc_pkg::*;

   // ===================================================================
   // register side declarations
   logic [ISC_CNT_W-1:0] hi_cnt_reg;
   logic [ISC_CNT_W-1:0] lo_cnt_reg;
   logic [ISC_ENT_W-1:0] entry_reg;
   logic [7:0] rx_data_reg;
   logic req_reg;
   logic ack_d_reg;
   logic rx_d_reg;
   logic [1:0] back_s;
   logic wr_data;
   logic rd_data;
   logic abort;
   logic accept;
   logic ack_ev;
   logic rx_ev;
   logic [ISC_CNT_W-1:0] wr_cnt;

   // ===================================================================
   // link side declarations
   logic [3:0] lk_ctl_s;
   logic [1:0] lk_pin_s;
   logic lk_en_d_reg;
   logic lk_scl_d_reg;
   logic [ISC_CNT_W-1:0] lk_hi_cnt_reg;
   logic [ISC_CNT_W-1:0] lk_lo_cnt_reg;
   isc_state_t lk_st;
   logic lk_hi;
   logic [3:0] lk_bit;
   logic [8:0] lk_sh;
   logic [8:0] lk_sh_n;
   logic lk_rd;
   logic lk_stp;
   logic lk_ack_reg;
   logic lk_rx_tgl_reg;
   logic [7:0] lk_rx_byte_reg;
   logic lk_load;
   logic [ISC_CNT_W-1:0] lk_val;
   logic tm_done;
   logic lk_new;
   logic lk_en;
   logic lk_fall;

   // ===================================================================
   // register port decode
   assign wr_data = reg_wr && (reg_addr == ISC_DATA_OFS);
   assign rd_data = reg_rd && (reg_addr == ISC_DATA_OFS);
   assign wr_cnt = reg_wdata[ISC_CNT_W-1:0];
   // read command aborted while general call is enabled in master mode, or after a read request
   assign abort = wr_data && reg_wdata[ISC_CMD_BIT]
      && ((master_mode && general_call_enable)
      || read_request_flag);
   assign accept = wr_data && !abort && !tx_queue_full;
   assign ack_ev = back_s[1] ^ ack_d_reg;
   assign rx_ev = back_s[0] ^ rx_d_reg;

   isc_sync #(.W(2)) u_back_sync (
      .clk(sys_clk),
      .rstn(rstn),
      .d({lk_ack_reg, lk_rx_tgl_reg}),
      .q(back_s)
   );

   // counts are frozen while enabled, so the link may read them later
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         hi_cnt_reg <= ISC_HI_RST;
         lo_cnt_reg <= ISC_LO_RST;
      end else if (reg_wr && !global_enable) begin
         if (reg_addr == ISC_HI_OFS) begin
            hi_cnt_reg <= (wr_cnt < ISC_HI_MIN) ? ISC_HI_MIN
               : wr_cnt;
         end
         if (reg_addr == ISC_LO_OFS) begin
            lo_cnt_reg <= (wr_cnt < ISC_LO_MIN) ? ISC_LO_MIN
               : wr_cnt;
         end
      end
   end

   // one-entry queue handed to the link by toggle handshake
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         entry_reg <= '0;
         req_reg <= 1'b0;
         tx_queue_full <= 1'b0;
         ack_d_reg <= 1'b0;
      end else begin
         ack_d_reg <= back_s[1];
         if (accept) begin
            entry_reg <= reg_wdata[ISC_ENT_W-1:0];
            req_reg <= ~req_reg;
         end
         if (accept) begin
            tx_queue_full <= 1'b1;
         end else if (ack_ev) begin
            tx_queue_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         tx_abort <= 1'b0;
      end else begin
         tx_abort <= abort;
      end
   end

   // received byte; a new byte in the read cycle keeps the flag set
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rx_data_reg <= '0;
         rx_full <= 1'b0;
         rx_d_reg <= 1'b0;
      end else begin
         rx_d_reg <= back_s[0];
         if (rx_ev) begin
            rx_data_reg <= lk_rx_byte_reg;
         end
         if (rx_ev) begin
            rx_full <= 1'b1;
         end else if (rd_data) begin
            rx_full <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            ISC_DATA_OFS: reg_rdata <= ISC_DW'(rx_data_reg);
            ISC_HI_OFS: reg_rdata <= ISC_DW'(hi_cnt_reg);
            ISC_LO_OFS: reg_rdata <= ISC_DW'(lo_cnt_reg);
            default: reg_rdata <= '0;
         endcase
      end
   end

   // ===================================================================
   // link side: synchronisers and phase timer
   isc_sync #(.W(4)) u_ctl_sync (
      .clk(link_clk),
      .rstn(link_rstn),
      .d({global_enable, master_mode, slave_tx_mode, req_reg}),
      .q(lk_ctl_s)
   );

   isc_sync #(.W(2)) u_pin_sync (
      .clk(link_clk),
      .rstn(link_rstn),
      .d({scl_i, sda_i}),
      .q(lk_pin_s)
   );

   isc_tmr #(.W(ISC_CNT_W)) u_tmr (
      .clk(link_clk),
      .rstn(link_rstn),
      .load(lk_load),
      .val(lk_val),
      .done(tm_done)
   );

   assign lk_en = lk_ctl_s[3];
   assign lk_new = (lk_ctl_s[0] != lk_ack_reg) && lk_en;
   assign lk_fall = lk_scl_d_reg && !lk_pin_s[1];
   assign lk_sh_n = {lk_sh[7:0], lk_pin_s[0]};

   // counts sampled once enable has settled here; they cannot move then
   always_ff @(posedge link_clk) begin
      if (!link_rstn) begin
         lk_en_d_reg <= 1'b0;
         lk_scl_d_reg <= 1'b0; // sync resets low: no false fall
         lk_hi_cnt_reg <= ISC_HI_RST;
         lk_lo_cnt_reg <= ISC_LO_RST;
      end else begin
         lk_en_d_reg <= lk_en;
         lk_scl_d_reg <= lk_pin_s[1];
         if (lk_en && !lk_en_d_reg) begin
            lk_hi_cnt_reg <= hi_cnt_reg;
            lk_lo_cnt_reg <= lo_cnt_reg;
         end
      end
   end

   // open drain: data outputs stay low, enables pull the wire
   always_ff @(posedge link_clk) begin
      if (!link_rstn) begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end
   end

   // ===================================================================
   // byte engine: 8 data bits then ack, msb first
   always_ff @(posedge link_clk) begin
      if (!link_rstn) begin
         lk_st <= ST_IDLE;
         lk_hi <= 1'b0;
         lk_bit <= '0;
         lk_sh <= '1;
         lk_rd <= 1'b0;
         lk_stp <= 1'b0;
         lk_ack_reg <= 1'b0;
         lk_rx_tgl_reg <= 1'b0;
         lk_rx_byte_reg <= '0;
         lk_load <= 1'b0;
         lk_val <= ISC_HI_RST;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         lk_load <= 1'b0;
         case (lk_st)
            ST_IDLE: begin
               scl_oe <= 1'b0;
               sda_oe <= 1'b0;
               if (lk_new) begin
                  lk_ack_reg <= ~lk_ack_reg;
                  lk_sh <= {entry_reg[7:0], 1'b1};
                  lk_rd <= entry_reg[ISC_CMD_BIT];
                  lk_stp <= entry_reg[ISC_STOP_BIT];
                  lk_bit <= '0;
                  if (lk_ctl_s[2]) begin
                     sda_oe <= 1'b1;
                     lk_val <= lk_hi_cnt_reg;
                     lk_load <= 1'b1;
                     lk_st <= ST_START;
                  end else if (lk_ctl_s[1]
                     && !entry_reg[ISC_CMD_BIT]) begin
                     lk_st <= ST_STX;
                  end
                  // slave receive drops the entry unused
               end
            end
            ST_START: begin
               if (tm_done) begin
                  scl_oe <= 1'b1;
                  sda_oe <= !lk_rd && !lk_sh[8];
                  lk_hi <= 1'b0;
                  lk_val <= lk_lo_cnt_reg;
                  lk_load <= 1'b1;
                  lk_st <= ST_BIT;
               end
            end
            ST_BIT: begin
               if (tm_done && !lk_hi) begin
                  scl_oe <= 1'b0;
                  lk_hi <= 1'b1;
                  lk_val <= lk_hi_cnt_reg;
                  lk_load <= 1'b1;
               end else if (tm_done) begin
                  scl_oe <= 1'b1;
                  lk_hi <= 1'b0;
                  lk_sh <= lk_sh_n;
                  if (lk_bit == ISC_LAST_BIT) begin
                     if (lk_rd) begin
                        lk_rx_byte_reg <= lk_sh[7:0];
                        lk_rx_tgl_reg <= ~lk_rx_tgl_reg;
                     end
                     if (lk_stp) begin
                        sda_oe <= 1'b1;
                        lk_val <= lk_lo_cnt_reg;
                        lk_load <= 1'b1;
                        lk_st <= ST_STOP;
                     end else begin
                        sda_oe <= 1'b0;
                        lk_st <= ST_WAIT;
                     end
                  end else begin
                     lk_bit <= lk_bit + 4'h1;
                     lk_val <= lk_lo_cnt_reg;
                     lk_load <= 1'b1;
                     if (lk_bit == ISC_LAST_BIT - 4'h1) begin
                        sda_oe <= lk_rd && !lk_stp;
                     end else begin
                        sda_oe <= !lk_rd && !lk_sh_n[8];
                     end
                  end
               end
            end
            ST_WAIT: begin
               // scl held low until the next entry arrives or enable drops
               if (lk_new) begin
                  lk_ack_reg <= ~lk_ack_reg;
                  lk_sh <= {entry_reg[7:0], 1'b1};
                  lk_rd <= entry_reg[ISC_CMD_BIT];
                  lk_stp <= entry_reg[ISC_STOP_BIT];
                  lk_bit <= '0;
                  sda_oe <= !entry_reg[ISC_CMD_BIT] && !entry_reg[7];
                  lk_val <= lk_lo_cnt_reg;
                  lk_load <= 1'b1;
                  lk_st <= ST_BIT;
               end else if (!lk_en) begin
                  lk_st <= ST_IDLE;
               end
            end
            ST_STOP: begin
               if (tm_done && !lk_hi) begin
                  scl_oe <= 1'b0;
                  lk_hi <= 1'b1;
                  lk_val <= lk_hi_cnt_reg;
                  lk_load <= 1'b1;
               end else if (tm_done) begin
                  sda_oe <= 1'b0;
                  lk_hi <= 1'b0;
                  lk_st <= ST_IDLE;
               end
            end
            ST_STX: begin
               // master owns scl; drive each bit after its falling edge
               if (lk_fall) begin
                  if (lk_bit == ISC_LAST_BIT) begin
                     sda_oe <= 1'b0;
                     lk_st <= ST_IDLE;
                  end else begin
                     sda_oe <= !lk_sh[8];
                     lk_sh <= {lk_sh[7:0], 1'b1};
                     lk_bit <= lk_bit + 4'h1;
                  end
               end
            end
            default: begin
               lk_st <= ST_IDLE;
            end
         endcase
      end
   end

   // ===================================================================
   // checks
   logic [ISC_CNT_W-1:0] a_rel_cnt;
   logic [ISC_CNT_W-1:0] a_low_cnt;
   always_ff @(posedge link_clk) begin
      if (!link_rstn || scl_oe) begin
         a_rel_cnt <= '0;
      end else begin
         a_rel_cnt <= a_rel_cnt + ISC_CNT_W'(1);
      end
      if (!link_rstn || !scl_oe) begin
         a_low_cnt <= '0;
      end else begin
         a_low_cnt <= a_low_cnt + ISC_CNT_W'(1);
      end
   end

   a_hi_clamp: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_wr && !global_enable && reg_addr == ISC_HI_OFS
      && wr_cnt < ISC_HI_MIN |=> hi_cnt_reg == ISC_HI_MIN)
      else $error("high count not clamped to minimum");
   a_lo_clamp: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_wr && !global_enable && reg_addr == ISC_LO_OFS |=> lo_cnt_reg
      == (($past(wr_cnt) < ISC_LO_MIN) ? ISC_LO_MIN : $past(wr_cnt)))
      else $error("low count wrong after write");
   a_cnt_locked: assert property (@(posedge sys_clk) disable iff (!rstn)
      global_enable |=> $stable(hi_cnt_reg) && $stable(lo_cnt_reg))
      else $error("count changed while enabled");
   a_cnt_reset: assert property (@(posedge sys_clk)
      !rstn |=> hi_cnt_reg == ISC_HI_RST && lo_cnt_reg == ISC_LO_RST)
      else $error("count reset value wrong");
   a_abort_gcall: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_data && reg_wdata[ISC_CMD_BIT] && master_mode
      && general_call_enable |=> tx_abort && $stable(req_reg))
      else $error("general call read not aborted");
   a_abort_rreq: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_data && reg_wdata[ISC_CMD_BIT] && read_request_flag
      |=> tx_abort ##1 (tx_abort == $past(abort)))
      else $error("read after read request not aborted");
   a_queue_entry: assert property (@(posedge sys_clk) disable iff (!rstn)
      accept |=> tx_queue_full && entry_reg == $past(reg_wdata[9:0]))
      else $error("entry not queued");
   a_read_data: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_data |=> reg_rdata == ISC_DW'($past(rx_data_reg)))
      else $error("data read wrong");
   a_scl_high: assert property (@(posedge link_clk)
      disable iff (!link_rstn)
      $rose(scl_oe) && $past(lk_st == ST_BIT) |-> a_rel_cnt == lk_hi_cnt_reg)
      else $error("scl high period wrong");
   a_scl_low: assert property (@(posedge link_clk)
      disable iff (!link_rstn)
      $fell(scl_oe) && lk_st == ST_BIT && lk_bit != 4'h0
      |-> a_low_cnt == lk_lo_cnt_reg)
      else $error("scl low period wrong");
   a_read_release: assert property (@(posedge link_clk)
      disable iff (!link_rstn)
      lk_st == ST_BIT && lk_rd && lk_bit < ISC_LAST_BIT |-> !sda_oe)
      else $error("sda driven during read");
   a_stop_end: assert property (@(posedge link_clk)
      disable iff (!link_rstn)
      lk_st == ST_BIT && tm_done && lk_hi && lk_stp
      && lk_bit == ISC_LAST_BIT |=> lk_st == ST_STOP && sda_oe)
      else $error("stop not started");

   c_abort: cover property (@(posedge sys_clk) disable iff (!rstn) tx_abort);
   c_rx: cover property (@(posedge sys_clk) disable iff (!rstn) rx_full);
   c_stop: cover property (@(posedge link_clk) disable iff (!link_rstn)
      lk_st == ST_STOP ##1 lk_st == ST_IDLE);
   c_stx: cover property (@(posedge link_clk) disable iff (!link_rstn)
      lk_st == ST_STX);
endmodule: isc_top

// file: bench/isc_i2c_peer.sv
/*
 * behavioural i2c target on the far side of the scl/sda wires.
 * assumes: wires resolved by the bench with pull-ups; no clock stretching.
 */
`timescale 1ns/1ps
module isc_i2c_peer (
   input wire logic scl,
   input wire logic sda,
   input wire logic rd_mode,
   input wire logic [7:0] tx_byte,
   output logic sda_pull
);
   int bit_cnt;
   int n_stop;
   logic busy, nack, quiet;
   logic [7:0] shift_reg;
   logic [7:0] got_q[$];

   // ===================================================================
   // framing
   initial begin
      bit_cnt = 0;
      n_stop = 0;
      shift_reg = 8'h00;
      sda_pull = 1'b0;
      {busy, nack, quiet} = '0;
   end
   // a stop counts only after a start, so power-up edges are ignored
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         bit_cnt = 0;
         busy = 1'b1;
         quiet = 1'b0;
      end
   end
   always @(posedge sda) begin
      if (scl === 1'b1 && busy) begin
         bit_cnt = 0;
         busy = 1'b0;
         n_stop++;
      end
   end

   // ===================================================================
   // bits: sample on rise, change only while scl is low
   always @(posedge scl) begin
      if (bit_cnt < 8) shift_reg = {shift_reg[6:0], sda};
      if (bit_cnt == 8) nack = sda;
      bit_cnt++;
      if (bit_cnt == 8 && !rd_mode) got_q.push_back(shift_reg);
   end
   always @(negedge scl) begin
      if (bit_cnt == 9) begin
         bit_cnt = 0;
         // a master's nack ends the read: stay off the wire until a start
         quiet = rd_mode && nack;
      end
      // read: data msb first, then let go for the master's ack
      if (!rd_mode) sda_pull = (bit_cnt == 8);
      else if (quiet || bit_cnt >= 8) sda_pull = 1'b0;
      else sda_pull = !tx_byte[7 - bit_cnt];
   end
endmodule: isc_i2c_peer

// file: bench/testbench.sv
/*
 * register-level tests of the i2c data/command port and scl counts.
 * assumes: isc_pkg compiled first; peer model on the resolved wires.
 */
`timescale 1ns/1ps
module testbench;
   import isc_pkg::*;
   logic sys_clk, rstn, link_clk, link_rstn, reg_wr, reg_rd;
   logic [ISC_AW-1:0] reg_addr;
   logic [ISC_DW-1:0] reg_wdata, reg_rdata;
   logic global_enable, master_mode, slave_tx_mode, general_call_enable;
   logic read_request_flag, tx_abort, tx_queue_full, rx_full;
   logic scl_o, scl_oe, sda_o, sda_oe, peer_pull, rd_mode, prev_oe;
   logic scl_w, sda_w, tb_scl_pull;
   logic [7:0] tx_byte;
   int n_errors, n_tests, run_len, last_lo, last_hi;

   // ===================================================================
   // clocks, wires, phase timer
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      link_clk = 1'b0;
      #3.7;
      forever #7.5 link_clk = ~link_clk;
   end
   assign scl_w = !(scl_oe | tb_scl_pull);
   // wire delay gives sda its hold time after scl falls
   assign #1 sda_w = !(sda_oe | peer_pull);
   always @(posedge link_clk) begin
      if (scl_oe === prev_oe) run_len++;
      else begin
         if (prev_oe) last_lo = run_len;
         else last_hi = run_len;
         run_len = 1;
      end
      prev_oe = scl_oe;
   end

   isc_top u_isc_top (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .global_enable(global_enable),
      .master_mode(master_mode), .slave_tx_mode(slave_tx_mode),
      .general_call_enable(general_call_enable),
      .read_request_flag(read_request_flag), .tx_abort(tx_abort),
      .tx_queue_full(tx_queue_full), .rx_full(rx_full),
      .link_clk(link_clk), .link_rstn(link_rstn), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe));
   isc_i2c_peer u_isc_i2c_peer (.scl(scl_w), .sda(sda_w),
      .rd_mode(rd_mode), .tx_byte(tx_byte), .sda_pull(peer_pull));

   // ===================================================================
   // tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask: check
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask: reg_write
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      #1;
      check(reg_rdata, exp);
   endtask: reg_read
   // what: 0 peer stop count reaches n, 1 rx_full high, 2 queue free
   task automatic wait_for(input int what, input int n);
      int i;
      for (i = 0; i < 5000; i++) begin
         @(posedge sys_clk);
         #1;
         if (what == 0 && u_isc_i2c_peer.n_stop == n) break;
         if (what == 1 && rx_full === 1'b1) break;
         if (what == 2 && tx_queue_full === 1'b0) break;
      end
      check(32'(i < 5000), 32'h1);
   endtask: wait_for
   // a refused entry must give exactly one pulse
   task automatic expect_abort;
      int hits;
      hits = 0;
      #1;
      repeat (4) begin
         hits += int'(tx_abort === 1'b1);
         @(posedge sys_clk);
         #1;
      end
      check(32'(hits), 32'h1);
   endtask: expect_abort
   // bench clocks scl as bus master: 9 clocks, first 8 sampled high
   task automatic slave_byte(input logic [7:0] exp);
      int i;
      logic [7:0] got;
      got = '0;
      for (i = 0; i < 9; i++) begin
         @(posedge sys_clk) tb_scl_pull <= 1'b1;
         repeat (10) @(posedge sys_clk);
         tb_scl_pull <= 1'b0;
         repeat (10) @(posedge sys_clk);
         if (i < 8) got = {got[6:0], sda_w};
      end
      check(32'(got), 32'(exp));
   endtask: slave_byte
   task automatic summarize;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask: summarize

   // ===================================================================
   // sequence
   initial begin
      {rstn, link_rstn, reg_wr, reg_rd, rd_mode, prev_oe, tb_scl_pull} = '0;
      {global_enable, slave_tx_mode, general_call_enable} = '0;
      {reg_addr, reg_wdata, read_request_flag} = '0;
      {n_errors, n_tests, run_len, last_lo, last_hi} = '0;
      master_mode = 1'b1;
      tx_byte = 8'h5a;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      link_rstn <= 1'b1;
      reg_read(ISC_HI_OFS, 32'h190);
      reg_read(ISC_LO_OFS, 32'h1d6);
      reg_read(ISC_DATA_OFS, 32'h0);
      reg_write(8'h1c, 32'hffff_ffff);
      reg_read(8'h1c, 32'h0);
      reg_write(ISC_HI_OFS, 32'hffff_ffff);
      reg_read(ISC_HI_OFS, 32'h3fff);
      reg_write(ISC_LO_OFS, 32'hffff_ffff);
      reg_read(ISC_LO_OFS, 32'h3fff);
      reg_write(ISC_HI_OFS, 32'h5);
      reg_read(ISC_HI_OFS, 32'h6);
      reg_write(ISC_LO_OFS, 32'h7);
      reg_read(ISC_LO_OFS, 32'h8);
      // counts go in before enabling, the link latches them then
      @(posedge sys_clk) global_enable <= 1'b1;
      repeat (8) @(posedge sys_clk);
      reg_write(ISC_HI_OFS, 32'h100);
      reg_read(ISC_HI_OFS, 32'h6);
      reg_write(ISC_DATA_OFS, 32'h0a5);
      wait_for(2, 0);
      reg_write(ISC_DATA_OFS, 32'h23c);
      wait_for(0, 1);
      check(32'(u_isc_i2c_peer.got_q[0]), 32'ha5);
      check(32'(u_isc_i2c_peer.got_q[1]), 32'h3c);
      check(32'(last_hi), 32'h6);
      check(32'(last_lo), 32'h8);
      @(posedge sys_clk) rd_mode <= 1'b1;
      reg_write(ISC_DATA_OFS, 32'h300);
      wait_for(1, 0);
      reg_read(ISC_DATA_OFS, 32'h5a);
      check({31'h0, rx_full}, 32'h0);
      wait_for(0, 2);
      @(posedge sys_clk) general_call_enable <= 1'b1;
      reg_write(ISC_DATA_OFS, 32'h100);
      expect_abort();
      @(posedge sys_clk) general_call_enable <= 1'b0;
      read_request_flag <= 1'b1;
      reg_write(ISC_DATA_OFS, 32'h100);
      expect_abort();
      check({31'h0, tx_queue_full}, 32'h0);
      // slave transmit, then slave receive with the direction bit set
      @(posedge sys_clk) master_mode <= 1'b0;
      slave_tx_mode <= 1'b1;
      rd_mode <= 1'b0;
      reg_write(ISC_DATA_OFS, 32'h0c3);
      wait_for(2, 0);
      slave_byte(8'hc3);
      @(posedge sys_clk) slave_tx_mode <= 1'b0;
      read_request_flag <= 1'b0;
      reg_write(ISC_DATA_OFS, 32'h1ff);
      wait_for(2, 0);
      check({30'h0, sda_oe, scl_oe}, 32'h0);
      check({30'h0, sda_o, scl_o}, 32'h0);
      summarize();
   end

   initial begin
      #1_000_000;
      n_errors++;
      summarize();
   end
endmodule: testbench
